/* File: verilog/asc_map.svh */
/*
  Constants for the static memory controller: pin levels, widths and
  access timing expressed as cycle counts of the 25 MHz system clock.
  Assumes it is included by bare name from files under verilog/.
*/
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// Memory geometry
`define ASC_ADDR_W        17
`define ASC_DATA_W        8
`define ASC_WORDS         131072

// Clock and timing figures
`define ASC_CLK_PERIOD_PS 40000
`define ASC_T_CYCLE_PS    12000
`define ASC_T_ACCESS_PS   12000
`define ASC_T_GATE_PS     6000
`define ASC_T_WPULSE_PS   8000

// Least times round up to whole cycles, never below one
`define ASC_CEIL_CYC(t) ((((t) + `ASC_CLK_PERIOD_PS - 1) / `ASC_CLK_PERIOD_PS) < 1 ? 1 : \
  (((t) + `ASC_CLK_PERIOD_PS - 1) / `ASC_CLK_PERIOD_PS))

// Cycles held per phase of an access; the access and cycle times tie as the longest figures
`define ASC_ACC_CYC  `ASC_CEIL_CYC(`ASC_T_ACCESS_PS)
`define ASC_WP_CYC   `ASC_CEIL_CYC(`ASC_T_WPULSE_PS)
`define ASC_CYC_CYC  `ASC_CEIL_CYC(`ASC_T_CYCLE_PS)

// Extra read hold for the two-flop data synchroniser, at counter width
`define ASC_SYNC_CYC 4'h2

// Pin levels and counter constants
`define ASC_STROBE_ON     1'b0
`define ASC_STROBE_OFF    1'b1
`define ASC_CNT_W         4
`define ASC_CNT_ZERO      4'h0
`define ASC_CNT_ONE       4'h1

`endif

/* File: verilog/asc_pkg.sv */
/*
  Types for the static memory controller.
  Assumes asc_map.svh sits on the include path.
*/
`include "asc_map.svh"

package asc_pkg;
  // Sequencer phases of one memory access
  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_RD_WAIT,
    ASC_WR_TURN,
    ASC_WR_PULSE,
    ASC_WR_END,
    ASC_RECOVER
  } asc_state_t;

  typedef logic [`ASC_ADDR_W-1:0] asc_addr_t;
  typedef logic [`ASC_DATA_W-1:0] asc_data_t;
endpackage

/* File: verilog/asc_sync.sv */
/*
  Two flip-flop synchroniser for a bus of pin inputs.
  Assumes clk is the controller clock and rst_n is the released reset.
*/
`timescale 1ns/1ps
`default_nettype none

module asc_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

`default_nettype wire

/* File: verilog/asc_ctrl.sv */
/*
  Controller for a 128K x 8 asynchronous static memory. Takes one-at-a-time
  read and write requests on a simple request port and sequences the select,
  write strobe and output gate pins, with the data pins as in/out/enable.
  Assumes a 25 MHz clk; the data pin level read back is asynchronous and is
  synchronised before use. The memory must meet its 12 ns access figures.
*/
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"

module asc_ctrl
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Request port
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic [`ASC_ADDR_W-1:0] req_addr,
  input  wire logic [`ASC_DATA_W-1:0] req_wdata,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic      [`ASC_DATA_W-1:0] rsp_rdata,
  // Memory pins
  output logic      [`ASC_ADDR_W-1:0] mem_addr,
  output logic                       select_active_low,
  output logic                       select_active_high,
  output logic                       mem_write_n,
  output logic                       mem_gate_n,
  input  wire logic [`ASC_DATA_W-1:0] data_in,
  output logic      [`ASC_DATA_W-1:0] data_out,
  output logic                       data_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation

  logic       rst_meta_r;
  logic       rst_n_r;
  asc_data_t  data_sync;

  // Asynchronous assert, synchronous release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  asc_sync #(.W(`ASC_DATA_W)) u_data_sync (
    .clk   (clk),
    .rst_n (rst_n_r),
    .d     (data_in),
    .q     (data_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  asc_state_t              state_r;
  asc_state_t              state_nxt;
  logic [`ASC_CNT_W-1:0]   cnt_r;
  logic [`ASC_CNT_W-1:0]   cnt_nxt;

  // Counter load: hold count minus one, since entry takes a cycle too
  function automatic logic [`ASC_CNT_W-1:0] hold_cnt(input int cyc);
    hold_cnt = `ASC_CNT_W'(cyc - 1);
  endfunction

  // Ready stays low for a cycle after reset release, so gate on it too
  wire take     = (state_r == ASC_IDLE) && req_valid && req_ready;
  wire cnt_done = (cnt_r == `ASC_CNT_ZERO);
  // Read data sits two flops behind the pins, so wait two more cycles
  wire [`ASC_CNT_W-1:0] rd_load = hold_cnt(`ASC_ACC_CYC) + `ASC_SYNC_CYC;

  // Next-state decode
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? cnt_r : cnt_r - `ASC_CNT_ONE;
    unique case (state_r)
      ASC_IDLE: begin
        if (take) begin
          state_nxt = req_write ? ASC_WR_TURN : ASC_RD_WAIT;
          cnt_nxt   = req_write ? `ASC_CNT_ZERO : rd_load;
        end
      end
      ASC_RD_WAIT: begin
        if (cnt_done) begin
          state_nxt = ASC_RECOVER;
          cnt_nxt   = hold_cnt(`ASC_CYC_CYC);
        end
      end
      ASC_WR_TURN: begin
        // Gate already high and data driven here, so memory outputs are off; strobe falls next
        state_nxt = ASC_WR_PULSE;
        cnt_nxt   = hold_cnt(`ASC_WP_CYC);
      end
      ASC_WR_PULSE: begin
        if (cnt_done) begin
          state_nxt = ASC_WR_END;
        end
      end
      ASC_WR_END: begin
        state_nxt = ASC_RECOVER;
        cnt_nxt   = hold_cnt(`ASC_CYC_CYC);
      end
      ASC_RECOVER: begin
        if (cnt_done) begin
          state_nxt = ASC_IDLE;
        end
      end
      // Unused codes fall back to idle
      default: begin
        state_nxt = ASC_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ASC_IDLE;
      cnt_r   <= `ASC_CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive, all from flops

  wire sel_nxt   = (state_nxt != ASC_IDLE) && (state_nxt != ASC_RECOVER);
  wire wr_nxt    = (state_nxt == ASC_WR_PULSE);
  wire rd_nxt    = (state_nxt == ASC_RD_WAIT);
  wire drive_nxt = (state_nxt == ASC_WR_TURN) || (state_nxt == ASC_WR_PULSE) ||
                   (state_nxt == ASC_WR_END);
  wire rsp_nxt   = (state_r == ASC_RD_WAIT) && cnt_done;

  // Strobes; gate stays high across a write, so data drive never meets memory output
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      select_active_low  <= `ASC_STROBE_OFF;
      select_active_high <= 1'b0;
      mem_write_n        <= `ASC_STROBE_OFF;
      mem_gate_n         <= `ASC_STROBE_OFF;
      data_oe            <= 1'b0;
    end else begin
      select_active_low  <= ~sel_nxt;
      select_active_high <= sel_nxt;
      mem_write_n        <= ~wr_nxt;
      mem_gate_n         <= ~rd_nxt;
      data_oe            <= drive_nxt;
    end
  end

  // Address and data latched at acceptance and held for the access
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mem_addr <= '0;
      data_out <= '0;
    end else if (take) begin
      mem_addr <= req_addr;
      data_out <= req_wdata;
    end
  end

  // Request handshake and read answer
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      req_ready <= (state_nxt == ASC_IDLE);
      rsp_valid <= rsp_nxt;
      if (rsp_nxt) begin
        rsp_rdata <= data_sync;
      end
    end
  end

endmodule

`default_nettype wire

/* File: dv/asc_ctrl_properties.sv */
/* Pin and request checks for asc_ctrl.
   Assumes it is bound to asc_ctrl. */
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module asc_ctrl_properties (
  // Clock, reset, request port
  input wire logic                   clk, nrst, req_valid, req_write, req_ready, rsp_valid,
  // Memory pins
  input wire logic [`ASC_ADDR_W-1:0] mem_addr,
  input wire logic                   select_active_low, select_active_high,
  input wire logic                   mem_write_n, mem_gate_n, data_oe
);
  // Both selects active, and a request taken
  wire sel  = !select_active_low && select_active_high;
  wire take = req_valid && req_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_write_sel: assert property (!mem_write_n |-> sel) else $error("strobe unselected");
  a_read_sel: assert property (!mem_gate_n |-> sel && mem_write_n)
    else $error("gate bad");
  a_drive_gated: assert property (data_oe |-> mem_gate_n) else $error("drive clash");
  a_addr_hold: assert property (sel && $past(sel) |-> $stable(mem_addr))
    else $error("addr moved");
  a_strobe_latch: assert property ($rose(mem_write_n) |-> sel && data_oe)
    else $error("strobe end bad");
  a_read_answer: assert property (take && !req_write |-> ##[1:8] rsp_valid)
    else $error("no read data");
  a_write_ready: assert property (take && req_write |=> !req_ready ##[1:6] req_ready)
    else $error("write ready");
  a_standby_gap: assert property ($fell(sel) |=> !sel) else $error("no standby");
  a_access_len: assert property ($rose(sel) |=> sel) else $error("short access");
endmodule
bind asc_ctrl asc_ctrl_properties u_asc_ctrl_properties (.*);
`default_nettype wire

/* File: dv/asc_sram_model.sv */
/* Behavioural 128K x 8 static memory.
   Assumes zero-delay pins; access times are far below one clock. */
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module asc_sram_model (
  // Pins from the controller
  input wire logic [`ASC_ADDR_W-1:0] mem_addr,
  input wire logic                   select_active_low, select_active_high,
  input wire logic                   mem_write_n, mem_gate_n, data_oe,
  input wire logic [`ASC_DATA_W-1:0] data_out,
  // Resolved wire and contention flag
  output logic     [`ASC_DATA_W-1:0] data_in,
  output logic                       clash
);
  logic [`ASC_DATA_W-1:0] mem [`ASC_WORDS];
  logic [`ASC_DATA_W-1:0] last = 8'h00;
  wire sel = !select_active_low && select_active_high;
  wire drv = sel && !mem_gate_n && mem_write_n;
  initial clash = 1'b0;
  // Released wire shows the inverse of its last level, so stale data never matches
  always @* if (drv) last = mem[mem_addr]; else if (data_oe) last = data_out;
  always @* data_in = drv ? mem[mem_addr] : data_oe ? data_out : ~last;
  // Strobe-ended and select-ended writes
  always @(posedge mem_write_n) if (sel) mem[mem_addr] = data_in;
  always @(posedge select_active_low or negedge select_active_high)
    if (!mem_write_n) mem[mem_addr] = data_in;
  always @* if (drv && data_oe) clash = 1'b1;
endmodule
`default_nettype wire

/* File: dv/tb_asc_ctrl.sv */
/* Bench for asc_ctrl against the memory model.
   Assumes design files and the model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"
module tb_asc_ctrl;
  import asc_pkg::*;
  logic      clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  asc_addr_t req_addr = '0, mem_addr;
  asc_data_t req_wdata = '0, rsp_rdata, data_in, data_out, got;
  logic      req_ready, rsp_valid, select_active_low, select_active_high;
  logic      mem_write_n, mem_gate_n, data_oe, clash;
  int        err_total = 0, compares = 0;
  always #20 clk = ~clk;
  asc_ctrl u_asc_ctrl (.*);
  asc_sram_model u_asc_sram_model (.*);
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string what, asc_data_t exp, asc_data_t seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A used-up wait ends the run
  task automatic tmo(int n);
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
  endtask
  // Request held until sampled with ready; a read waits for its pulse
  task automatic access(logic wr, asc_addr_t a, asc_data_t d);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 20);
    req_valid <= 1'b0;
    tmo(n);
    n = 0;
    if (!wr) do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 20);
    got = rsp_rdata;
    tmo(n);
  endtask
  task automatic do_reset();
    int n;
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 20);
    tmo(n);
    // Ready rises at the third edge after release, seen here at the fourth
    chk("ready edges", 8'h04, 8'(n));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic sc_idle();
    chk("idle pins", 8'h16, {select_active_low, select_active_high, mem_write_n,
        mem_gate_n, data_oe});
  endtask
  // Both ends of the range, back to back, with an overwrite
  task automatic sc_ends();
    access(1'b1, 17'h00000, 8'h3c);
    access(1'b1, 17'h1ffff, 8'hc3);
    access(1'b1, 17'h00000, 8'h5a);
    access(1'b0, 17'h1ffff, 8'h00);
    chk("top byte", 8'hc3, got);
    access(1'b0, 17'h00000, 8'h00);
    chk("low byte", 8'h5a, got);
  endtask
  // Walking address bit catches swapped or stuck address pins
  task automatic sc_walk();
    for (int i = 0; i < `ASC_ADDR_W; i++) access(1'b1, 17'h00001 << i, 8'(i) * 8'h0d + 8'h07);
    for (int i = 0; i < `ASC_ADDR_W; i++) begin
      access(1'b0, 17'h00001 << i, 8'h00);
      chk("walk byte", 8'(i) * 8'h0d + 8'h07, got);
    end
  endtask
  // Reset right after a write is taken, before its strobe falls: the write
  // is dropped and the memory, which has no reset, keeps its old byte
  task automatic sc_midreset();
    access(1'b1, 17'h00100, 8'ha5);
    access(1'b1, 17'h00100, 8'h96);
    do_reset();
    sc_idle();
    access(1'b0, 17'h00100, 8'h00);
    chk("kept byte", 8'ha5, got);
  endtask
  initial begin
    do_reset();
    sc_idle();
    sc_ends();
    sc_walk();
    sc_midreset();
    chk("contention", 8'h00, {7'h00, clash});
    print_verdict();
  end
endmodule
`default_nettype wire
